// [verilog/dual_sample_timing.v]
// Contract
// R1 - Dual mode converts pair An/Bn, n 0-7
// R2 - Start on PWM, software or pin trigger
// R3 - Select bit 1: both channels per pulse
// R4 - Both channels captured at hold falling edge
// R5 - Hold pulse lasts 1 plus count clocks
// R6 - Sampling starts 2.5 converter clocks after trigger
// R7 - First results: A after 4, B after 5
// R8 - Later results every 3 plus count clocks
// R9 - Interrupt flag follows result update shortly
// R10 - Select bit 0: one channel per pulse
// R11 - Acquisition count latched on accepted trigger
`include "dual_sample_timing_defs.vh"

module dual_sample_timing (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   pwmTrigger,
  input  wire                   swTrigger,
  input  wire                   extConvertTrigger,
  input  wire                   dualSampleSelect,
  input  wire                   continuousRun,
  input  wire [3:0]             channelSelect,
  input  wire [15:0]            converterControlOne,
  input  wire [`RESULT_W-1:0]   chanAData,
  input  wire [`RESULT_W-1:0]   chanBData,
  output reg  [2:0]             pairSelect,
  output reg                    sampleHold,
  output reg                    sampleStrobe,
  output reg  [`RESULT_W-1:0]   resultA,
  output reg  [`RESULT_W-1:0]   resultB,
  output reg                    resultAUpdate,
  output reg                    resultBUpdate,
  output reg                    convIntFlag,
  output wire                   busy
);

  // Header counts are plain integers; cut to counter width on purpose
  localparam integer DIV_INT   = `CONV_DIV_CYC;
  localparam integer TRIG_INT  = `TRIG_DELAY_CYC;
  localparam integer GAP_INT   = `GAP_CYC;
  localparam [7:0]   DIV_CYC   = DIV_INT[7:0];
  localparam [7:0]   TRIG_CYC  = TRIG_INT[7:0];
  localparam [7:0]   GAP_CYC   = GAP_INT[7:0];
  localparam       A_LEN     = `RES_A_CYC;
  localparam       B_LEN     = `RES_B_CYC;
  localparam       I_LEN     = `INT_LAG_CYC;

  localparam [3:0] S_IDLE  = 4'h1;
  localparam [3:0] S_DELAY = 4'h2;
  localparam [3:0] S_HOLD  = 4'h4;
  localparam [3:0] S_GAP   = 4'h8;

  reg  [3:0]            state;
  reg  [7:0]            cnt;
  reg  [3:0]            acqLatch;
  reg                   dualLatch;
  reg                   selB;
  reg  [A_LEN-1:0]      aPipe;
  reg  [B_LEN-1:0]      bPipe;
  reg  [I_LEN-1:0]      intPipe;
  reg  [A_LEN-1:0]      sPipe;
  reg                   wrPtr;
  reg                   wrPtrB;
  reg                   rdPtrA;
  reg                   rdPtrB;
  wire [1:0]            wrSelA;
  wire [1:0]            wrSelB;
  wire [`RESULT_W-1:0]  slotAOut [0:1];
  wire [`RESULT_W-1:0]  slotBOut [0:1];
  genvar                g;

  wire       trigger = pwmTrigger | swTrigger | extConvertTrigger; // [R2]
  wire [7:0] holdCyc = ({4'h0, acqLatch} + 8'h01) * DIV_CYC;       // [R5]
  wire       capture = state[2] & (cnt == holdCyc - 8'h01);
  // Mode rides with each sample, so a new trigger cannot steal a flag
  wire       lastUpd = bPipe[B_LEN-1] | sPipe[A_LEN-1];

  assign busy   = ~state[0];
  assign wrSelA = {wrPtr, ~wrPtr};
  assign wrSelB = {wrPtrB, ~wrPtrB};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= S_IDLE;
      cnt          <= 8'h00;
      acqLatch     <= 4'h0;
      dualLatch    <= 1'b0;
      selB         <= 1'b0;
      pairSelect   <= 3'h0;
      sampleHold   <= 1'b0;
      sampleStrobe <= 1'b0;
      wrPtr        <= 1'b0;
      wrPtrB       <= 1'b0;
    end else begin
      sampleStrobe <= 1'b0;
      case (state)
        S_IDLE: begin
          // Triggers during a run are ignored, not queued
          if (trigger) begin
            acqLatch   <= converterControlOne[`ACQ_MSB:`ACQ_LSB]; // [R11]
            dualLatch  <= dualSampleSelect;
            pairSelect <= channelSelect[2:0];                  // [R1]
            selB       <= channelSelect[3];
            cnt        <= 8'h00;
            state      <= S_DELAY;
          end
        end
        S_DELAY: begin
          // Whole-cycle count of the 2.5 converter clock lead
          if (cnt == TRIG_CYC - 8'h01) begin                   // [R6]
            cnt        <= 8'h00;
            sampleHold <= 1'b1;
            state      <= S_HOLD;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        S_HOLD: begin
          if (capture) begin                                   // [R4]
            sampleHold   <= 1'b0;
            sampleStrobe <= 1'b1;
            wrPtr        <= ~wrPtr;
            if (dualLatch) begin
              wrPtrB     <= ~wrPtrB;
            end
            cnt          <= 8'h00;
            state        <= continuousRun ? S_GAP : S_IDLE;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        S_GAP: begin
          // Hold plus gap gives a 3 plus count clock period
          if (!continuousRun) begin
            state <= S_IDLE;
          end else if (cnt == GAP_CYC - 8'h01) begin           // [R8]
            cnt        <= 8'h00;
            sampleHold <= 1'b1;
            state      <= S_HOLD;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          state      <= S_IDLE;
          sampleHold <= 1'b0;
        end
      endcase
    end
  end

  // Two slots suffice: samples are at least 24 cycles apart,
  // the slowest result trails its capture by 40
  generate
    for (g = 0; g < 2; g = g + 1) begin : gSlot
      reg [`RESULT_W-1:0] aEntry;
      reg [`RESULT_W-1:0] bEntry;
      // B has its own pointer, as single-mode samples skip it
      always @(posedge clk) begin
        if (capture && wrSelA[g]) begin                        // [R4]
          if (dualLatch || !selB) begin                        // [R10]
            aEntry <= chanAData;
          end else begin
            aEntry <= chanBData;
          end
        end
        if (capture && dualLatch && wrSelB[g]) begin           // [R3]
          bEntry <= chanBData;
        end
      end
      assign slotAOut[g] = aEntry;
      assign slotBOut[g] = bEntry;
    end
  endgenerate

  // A result path: every sample, flag source in single mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aPipe         <= {A_LEN{1'b0}};
      sPipe         <= {A_LEN{1'b0}};
      rdPtrA        <= 1'b0;
      resultA       <= {`RESULT_W{1'b0}};
      resultAUpdate <= 1'b0;
    end else begin
      aPipe         <= {aPipe[A_LEN-2:0], capture};           // [R7]
      sPipe         <= {sPipe[A_LEN-2:0], capture & ~dualLatch};
      resultAUpdate <= aPipe[A_LEN-1];
      if (aPipe[A_LEN-1]) begin
        resultA <= slotAOut[rdPtrA];
        rdPtrA  <= ~rdPtrA;
      end
    end
  end

  // B result path: dual-mode samples only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bPipe         <= {B_LEN{1'b0}};
      rdPtrB        <= 1'b0;
      resultB       <= {`RESULT_W{1'b0}};
      resultBUpdate <= 1'b0;
    end else begin
      bPipe         <= {bPipe[B_LEN-2:0], capture & dualLatch}; // [R7]
      resultBUpdate <= bPipe[B_LEN-1];
      if (bPipe[B_LEN-1]) begin
        resultB <= slotBOut[rdPtrB];
        rdPtrB  <= ~rdPtrB;
      end
    end
  end

  // Interrupt path: fixed lag behind the last update of a sample
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intPipe     <= {I_LEN{1'b0}};
      convIntFlag <= 1'b0;
    end else begin
      intPipe     <= {intPipe[I_LEN-2:0], lastUpd};
      // Flag strictly after the register write, never with it
      convIntFlag <= intPipe[I_LEN-1];                         // [R9]
    end
  end

endmodule // dual_sample_timing

// [verilog/dual_sample_timing_defs.vh]
`ifndef DUAL_SAMPLE_TIMING_DEFS_VH
`define DUAL_SAMPLE_TIMING_DEFS_VH

// Clock periods in ns
`define SYS_PERIOD_NS      10
`define CONV_PERIOD_NS     80

// System clocks per converter clock
`define CONV_DIV_CYC       (`CONV_PERIOD_NS / `SYS_PERIOD_NS)

// Trigger to sampling: 2.5 converter clocks, in tenths
`define TRIG_DELAY_TENTHS  25
`define TRIG_DELAY_CYC     ((`TRIG_DELAY_TENTHS * `CONV_PERIOD_NS) / (10 * `SYS_PERIOD_NS))

// Result latencies after sampling, converter clocks
`define RES_A_CONV         4
`define RES_B_CONV         5
`define RES_A_CYC          (`RES_A_CONV * `CONV_DIV_CYC)
`define RES_B_CYC          (`RES_B_CONV * `CONV_DIV_CYC)

// Extra converter clocks between holds beyond hold width
`define GAP_CONV           2
`define GAP_CYC            (`GAP_CONV * `CONV_DIV_CYC)

// Interrupt flag lag after result update, system clocks
`define INT_LAG_CYC        2

// Field layout of converter_control_one acquisition count
`define ACQ_LSB            8
`define ACQ_MSB            11

`define RESULT_W           12

`endif

// [tb/dual_sample_timing_props.sv]
`include "dual_sample_timing_defs.vh"
module dual_sample_timing_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        busy,
  input wire logic        pwmTrigger,
  input wire logic        swTrigger,
  input wire logic        extConvertTrigger,
  input wire logic        dualSampleSelect,
  input wire logic [15:0] converterControlOne,
  input wire logic [2:0]  pairSelect,
  input wire logic        sampleHold,
  input wire logic        sampleStrobe,
  input wire logic        convIntFlag,
  input wire logic        resultAUpdate,
  input wire logic        resultBUpdate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] acqL;
  logic       dualL;
  logic [7:0] holdCnt;
  wire trig = !busy && (pwmTrigger || swTrigger || extConvertTrigger);
  // Own copy of the count, so a field change mid-pulse is caught
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) {acqL, dualL, holdCnt} <= '0;
    else begin
      if (trig) acqL <= converterControlOne[`ACQ_MSB:`ACQ_LSB];
      if (trig) dualL <= dualSampleSelect;
      holdCnt <= sampleHold ? holdCnt + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  hold_start_a: assert property (
    trig |-> ##20 !sampleHold ##1 sampleHold) else $error("hold start");
  capture_edge_a: assert property (
    $fell(sampleHold) |-> sampleStrobe) else $error("capture edge");
  hold_width_a: assert property (
    $fell(sampleHold) |-> holdCnt == ({4'h0, acqL} + 8'h01) << 3)
    else $error("hold width");
  a_latency_a: assert property (
    sampleStrobe |-> ##32 resultAUpdate) else $error("A latency");
  b_latency_a: assert property (
    sampleStrobe && dualL |-> ##40 resultBUpdate) else $error("B latency");
  single_no_b_a: assert property (
    sampleStrobe && !dualL |-> ##40 !resultBUpdate) else $error("B seen");
  flag_lag_a: assert property (
    convIntFlag |-> $past(resultBUpdate, 2) || $past(resultAUpdate, 2))
    else $error("flag lag");
  flag_dual_a: assert property (
    sampleStrobe && dualL |-> ##42 convIntFlag) else $error("dual flag");
  flag_single_a: assert property (
    sampleStrobe && !dualL |-> ##34 convIntFlag) else $error("single flag");
  pair_hold_a: assert property (
    sampleHold |-> $stable(pairSelect)) else $error("pair moved");
  cover property (resultBUpdate);
  cover property (sampleStrobe && !dualL);
  cover property ($fell(sampleHold) && acqL == 4'hF);
endmodule // dual_sample_timing_props
bind dual_sample_timing dual_sample_timing_props i_props (
  .clk                 (clk),
  .rst_n               (rst_n),
  .busy                (busy),
  .pwmTrigger          (pwmTrigger),
  .swTrigger           (swTrigger),
  .extConvertTrigger   (extConvertTrigger),
  .dualSampleSelect    (dualSampleSelect),
  .converterControlOne (converterControlOne),
  .pairSelect          (pairSelect),
  .sampleHold          (sampleHold),
  .sampleStrobe        (sampleStrobe),
  .convIntFlag         (convIntFlag),
  .resultAUpdate       (resultAUpdate),
  .resultBUpdate       (resultBUpdate)
);

// [tb/pair_source.sv]
module pair_source (
  input  wire logic [2:0]  pairSelect,
  input  wire logic [7:0]  dataSeed,
  input  wire logic        sampleHold,
  output logic      [11:0] chanAData,
  output logic      [11:0] chanBData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Inputs drift off hold, so a late capture reads junk
  wire [7:0] v = sampleHold ? dataSeed : ~dataSeed;
  assign chanAData = {pairSelect, 1'b0, v};
  assign chanBData = {pairSelect, 1'b1, ~v};
endmodule // pair_source

// [tb/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, pwmTrigger = 0, swTrigger = 0;
  logic extConvertTrigger = 0, dualSampleSelect = 0, continuousRun = 0;
  logic [3:0]  channelSelect = 0;
  logic [15:0] converterControlOne = 0;
  logic [7:0]  dataSeed = 0;
  logic [2:0]  pairSelect;
  logic sampleHold, sampleStrobe, resultAUpdate, resultBUpdate, convIntFlag;
  logic busy;
  logic [11:0] chanAData, chanBData, resultA, resultB;
  int fails = 0, testsRun = 0;
  always #5 clk = ~clk;
  dual_sample_timing i_dut (
    .clk                 (clk),
    .rst_n               (rst_n),
    .pwmTrigger          (pwmTrigger),
    .swTrigger           (swTrigger),
    .extConvertTrigger   (extConvertTrigger),
    .dualSampleSelect    (dualSampleSelect),
    .continuousRun       (continuousRun),
    .channelSelect       (channelSelect),
    .converterControlOne (converterControlOne),
    .chanAData           (chanAData),
    .chanBData           (chanBData),
    .pairSelect          (pairSelect),
    .sampleHold          (sampleHold),
    .sampleStrobe        (sampleStrobe),
    .resultA             (resultA),
    .resultB             (resultB),
    .resultAUpdate       (resultAUpdate),
    .resultBUpdate       (resultBUpdate),
    .convIntFlag         (convIntFlag),
    .busy                (busy)
  );
  pair_source i_src (
    .pairSelect (pairSelect),
    .dataSeed   (dataSeed),
    .sampleHold (sampleHold),
    .chanAData  (chanAData),
    .chanBData  (chanBData)
  );
  function automatic logic [11:0] expd(logic [3:0] n, logic b);
    return {n[2:0], b, b ? ~dataSeed : dataSeed};
  endfunction
  task chk(string nm, logic [11:0] seen, exp);
    testsRun++;
    if (seen !== exp) fails++;
    if (seen !== exp) $display("Error %s exp %h seen %h", nm, exp, seen);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic shot(int src, logic d, c, logic [3:0] n, acq);
    logic [11:0] oldB;
    int t;
    @(posedge clk);
    oldB = resultB;
    {extConvertTrigger, swTrigger, pwmTrigger} <= 3'h1 << src;
    {dualSampleSelect, continuousRun, channelSelect} <= {d, c, n};
    converterControlOne <= {4'($urandom), acq, 8'($urandom)};
    dataSeed <= 8'($urandom);
    @(posedge clk);
    {extConvertTrigger, swTrigger, pwmTrigger} <= 3'h0;
    converterControlOne <= 16'($urandom);
    for (t = 1; t < 400 && resultAUpdate !== 1'b1; t++) @(negedge clk);
    chk("resultAUpdate", resultAUpdate, 12'h001);
    chk("resultA", resultA, expd(n, n[3] && !d));
    if (c) begin
      @(negedge clk);
      for (t = 1; t < 400 && resultAUpdate !== 1'b1; t++) @(negedge clk);
      chk("period", 12'(t), 12'((3 + acq) * 8));
      @(posedge clk);
      continuousRun <= 1'b0;
    end
    for (t = 0; t < 400 && busy !== 1'b0; t++) @(negedge clk);
    chk("busy", busy, 12'h000);
    repeat (48) @(negedge clk);
    chk("resultB", resultB, d ? expd(n, 1'b1) : oldB);
  endtask
  initial begin
    void'($urandom(32'hA680));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 30; i++)
      shot(i % 3, i < 2 || 1'($urandom), i % 4 == 3, 4'($urandom),
        i == 0 ? 4'h0 : i == 1 ? 4'hF : 4'($urandom));
    end_sim;
  end
  initial begin
    #400000 fails++;
    end_sim;
  end
endmodule // tb_top
